// File: hw/maskable_irq_map.vh
// constants for the maskable interrupt control flags block
`ifndef MASKABLE_IRQ_MAP_VH
`define MASKABLE_IRQ_MAP_VH

// number of maskable sources and priority levels
`define IRQ_NUM_SRC 25
`define IRQ_NUM_LEVELS 4

// source control registers: source n sits at IRQ_CTRL_BASE + n
`define IRQ_CTRL_BASE 16'hFFE1
`define IRQ_CTRL_LAST 16'hFFF9
`define IRQ_CTRL_BUS1 16'hFFF6
`define IRQ_CTRL_BUS2 16'hFFF7
`define IRQ_CTRL_WATCH 16'hFFF8
`define IRQ_CTRL_SERIAL3 16'hFFF9

// mask word registers (low byte at even address, high byte at odd)
`define IRQ_MASK_LO_ADDR 16'hFFAC
`define IRQ_MASK_HI_ADDR 16'hFFAE

// control register field positions
`define IRQ_BIT_PEND 7
`define IRQ_BIT_BLOCK 6
`define IRQ_BIT_HWXFER 5
`define IRQ_BIT_BANK 4
`define IRQ_BIT_LVL_HI 1
`define IRQ_BIT_LVL_LO 0

// reset values
`define IRQ_CTRL_RESET 8'h43
`define IRQ_LVL_RESET 2'h3
`define IRQ_MASK_RESET 16'hFFFF
`define IRQ_ISR_RESET 4'h0

// default positions whose request is shared by two serial modes
`define IRQ_SHARED_A 15
`define IRQ_SHARED_B 19

`endif

// File: hw/source_ctrl_cell.v
// one source control register: pending, block, transfer select, bank select, level
`timescale 1ns/1ps
`include "maskable_irq_map.vh"

module source_ctrl_cell (
	// clock and reset
	input wire sys_clk,
	input wire rst,
	// hardware events
	input wire reqPulse,
	input wire ackClr,
	input wire xferDone,
	// byte write to the control register
	input wire ctlWr,
	input wire [7:0] wrData,
	input wire [7:0] wrMask,
	// write through the mask word registers
	input wire blkWr,
	input wire blkVal,
	// register contents
	output wire [7:0] ctrlByte
);

reg pend_ff;
reg blk_ff;
reg hwXfer_ff;
reg bank_ff;
reg [1:0] lvl_ff;

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		pend_ff <= 1'b0;
		blk_ff <= 1'b1;
		hwXfer_ff <= 1'b0;
		bank_ff <= 1'b0;
		lvl_ff <= `IRQ_LVL_RESET;
	end else begin
		// a request in the same cycle as any clear still lands
		if (ctlWr && wrMask[`IRQ_BIT_PEND])
			pend_ff <= wrData[`IRQ_BIT_PEND];
		if (ackClr)
			pend_ff <= 1'b0;
		if (reqPulse)
			pend_ff <= 1'b1;
		// only software touches the block bit, from either path
		if (ctlWr && wrMask[`IRQ_BIT_BLOCK])
			blk_ff <= wrData[`IRQ_BIT_BLOCK];
		if (blkWr)
			blk_ff <= blkVal;
		if (xferDone)
			hwXfer_ff <= 1'b0;
		if (ctlWr && wrMask[`IRQ_BIT_HWXFER])
			hwXfer_ff <= wrData[`IRQ_BIT_HWXFER];
		if (ctlWr && wrMask[`IRQ_BIT_BANK])
			bank_ff <= wrData[`IRQ_BIT_BANK];
		if (ctlWr && wrMask[`IRQ_BIT_LVL_HI])
			lvl_ff[1] <= wrData[`IRQ_BIT_LVL_HI];
		if (ctlWr && wrMask[`IRQ_BIT_LVL_LO])
			lvl_ff[0] <= wrData[`IRQ_BIT_LVL_LO];
	end
end

// bits 3 and 2 have no storage
assign ctrlByte = {pend_ff, blk_ff, hwXfer_ff, bank_ff, 2'b00, lvl_ff};

endmodule // source_ctrl_cell

// File: hw/level_arbiter.v
// picks the best candidate: lowest level number, then lowest default position
`timescale 1ns/1ps

module level_arbiter #(
	parameter NUM_SRC = 25
) (
	// candidates and their levels, two bits per source
	input wire [NUM_SRC-1:0] candidate,
	input wire [2*NUM_SRC-1:0] levels,
	// winner
	output reg found,
	output reg [4:0] winId,
	output reg [1:0] winLvl
);

integer i;

always @* begin
	found = 1'b0;
	winId = 5'h0;
	winLvl = 2'h3;
	// strict compare keeps the earlier default position on a tie
	for (i = 0; i < NUM_SRC; i = i + 1) begin
		if (candidate[i] && (!found || (levels[2*i +: 2] < winLvl))) begin
			found = 1'b1;
			winId = i[4:0];
			winLvl = levels[2*i +: 2];
		end
	end
end

endmodule // level_arbiter

// File: hw/maskable_irq_control_flags.v
// per-source control flags, mask word aliases and request selection for maskable interrupts
`timescale 1ns/1ps
`include "maskable_irq_map.vh"

// Summary of operation
// - each of 25 sources has a two-bit level; 0 highest; levels may be shared
// - level field in bits 1:0, 00 is level 0 through 11 is level 3
// - equal-level simultaneous requests go in default order 0 up to 24
// - reset sets every level field to 11, the lowest level
// - bank select bit 4 set asks for register bank switching on acknowledge
// - transfer select bit 5 routes the request to hardware transfer service
// - transfer completion clears that source's transfer select bit
// - block bit 6 set prevents acknowledge of the source
// - the block bit stops hardware transfer requests as well as vectored ones
// - acknowledge never changes a block bit; only software writes do
// - pending bit 7 set by request, cleared on acknowledge, software writable
// - mask words are 16 bits, writable as word, byte or single bit
// - mask word bits 0 to 24 and control register block bits are the same storage; bits 25 to 31 read as ones
// - reset sets both mask words to all ones
// - last four control registers at FFF6 to FFF9, reset 43, bits 3:2 zero
// - two serial source pairs each share one request, selected by mode
// - hardware transfer requests ignore levels and the global allow bit
// - vectored acknowledge sets the in-service bit of its level until service ends
module maskable_irq_control_flags #(
	parameter NUM_SRC = `IRQ_NUM_SRC
) (
	// clock and reset
	input wire sys_clk,
	input wire rst,
	// register port from the cpu
	input wire [15:0] cpuAddr,
	input wire cpuWr,
	input wire cpuRd,
	input wire [15:0] cpuWrData,
	input wire [15:0] cpuWrMask,
	output reg [15:0] cpuRdData,
	// peripheral request pulses, one per default position
	input wire [NUM_SRC-1:0] srcReq,
	// shared serial positions: mode 1 selects the clocked serial request
	input wire asyncReceiveRequest1,
	input wire clockedSerial1Request,
	input wire serialMode1,
	input wire asyncReceiveRequest2,
	input wire clockedSerial2Request,
	input wire serialMode2,
	// cpu state
	input wire globalMaskableAllow,
	input wire serviceEnd,
	output wire [3:0] inServiceLevels,
	// vectored or bank switch request to the cpu
	output wire vecReq,
	output reg [4:0] vecId,
	output reg [1:0] vecLvl,
	output reg vecBankSwitch,
	input wire vecAck,
	// hardware transfer request to the transfer engine
	output wire hwReq,
	output reg [4:0] hwId,
	input wire hwAck,
	input wire hwDone,
	input wire [4:0] hwDoneId
);

wire [NUM_SRC-1:0] reqIn;
wire [8*NUM_SRC-1:0] ctrlBytes;
wire [NUM_SRC-1:0] pendVec;
wire [NUM_SRC-1:0] blkVec;
wire [NUM_SRC-1:0] hwSelVec;
wire [2*NUM_SRC-1:0] lvlVec;
wire [NUM_SRC-1:0] vecCand;
wire [NUM_SRC-1:0] hwCand;
wire vecFound;
wire [4:0] vecWinId;
wire [1:0] vecWinLvl;
wire hwFound;
wire [4:0] hwWinId;
wire [15:0] ctrlOffset;
wire ctrlHit;
wire [4:0] ctrlIdx;
wire maskLoHit;
wire maskHiHit;
wire [15:0] maskData;
wire [15:0] maskBits;
wire [31:0] maskWrEn;
wire [31:0] maskWrVal;
wire [31:0] maskRd;
wire vecAckOk;
wire hwAckOk;
wire eligible;
reg vecReq_ff;
reg hwReq_ff;
reg [3:0] isr_ff;
reg [3:0] isrClr;
reg [2:0] isrLimit;
reg [15:0] nxt_rdData;
integer k;

// shared positions: only one of each serial pair can drive the request
assign reqIn[`IRQ_SHARED_A] = serialMode1 ? clockedSerial1Request : asyncReceiveRequest1;
assign reqIn[`IRQ_SHARED_B] = serialMode2 ? clockedSerial2Request : asyncReceiveRequest2;

// address decode
assign ctrlOffset = cpuAddr - `IRQ_CTRL_BASE;
assign ctrlHit = (cpuAddr >= `IRQ_CTRL_BASE) && (cpuAddr <= `IRQ_CTRL_LAST);
assign ctrlIdx = ctrlOffset[4:0];
assign maskLoHit = ({cpuAddr[15:1], 1'b0} == `IRQ_MASK_LO_ADDR);
assign maskHiHit = ({cpuAddr[15:1], 1'b0} == `IRQ_MASK_HI_ADDR);

// odd address is a byte access to the high half, carried on data bits 7:0
assign maskData = cpuAddr[0] ? {cpuWrData[7:0], 8'h00} : cpuWrData;
assign maskBits = cpuAddr[0] ? {cpuWrMask[7:0], 8'h00} : cpuWrMask;
assign maskWrEn = {(cpuWr && maskHiHit) ? maskBits : 16'h0000, (cpuWr && maskLoHit) ? maskBits : 16'h0000};
assign maskWrVal = {maskData, maskData};

// acknowledge is honoured only for a source still pending and unblocked
assign vecAckOk = vecAck && vecReq_ff && pendVec[vecId] && !blkVec[vecId];
assign hwAckOk = hwAck && hwReq_ff && pendVec[hwId] && !blkVec[hwId];

genvar g;
generate
	for (g = 0; g < NUM_SRC; g = g + 1) begin : gSrc
		if (g != `IRQ_SHARED_A && g != `IRQ_SHARED_B) begin : gDirect
			assign reqIn[g] = srcReq[g];
		end
		source_ctrl_cell uCell (
			.sys_clk(sys_clk),
			.rst(rst),
			.reqPulse(reqIn[g]),
			.ackClr((vecAckOk && (vecId == g)) || (hwAckOk && (hwId == g))),
			.xferDone(hwDone && (hwDoneId == g)),
			.ctlWr(cpuWr && ctrlHit && (ctrlIdx == g)),
			.wrData(cpuWrData[7:0]),
			.wrMask(cpuWrMask[7:0]),
			.blkWr(maskWrEn[g]),
			.blkVal(maskWrVal[g]),
			.ctrlByte(ctrlBytes[8*g +: 8])
		);
		assign pendVec[g] = ctrlBytes[8*g + `IRQ_BIT_PEND];
		assign blkVec[g] = ctrlBytes[8*g + `IRQ_BIT_BLOCK];
		assign hwSelVec[g] = ctrlBytes[8*g + `IRQ_BIT_HWXFER];
		assign lvlVec[2*g +: 2] = ctrlBytes[8*g +: 2];
		assign vecCand[g] = pendVec[g] && !blkVec[g] && !hwSelVec[g];
		assign hwCand[g] = pendVec[g] && !blkVec[g] && hwSelVec[g];
	end
	for (g = 0; g < 32; g = g + 1) begin : gMaskRd
		if (g < NUM_SRC) begin : gLive
			assign maskRd[g] = blkVec[g];
		end else begin : gSpare
			assign maskRd[g] = 1'b1;
		end
	end
endgenerate

// vectored path obeys levels; transfer path takes the earliest position
level_arbiter #(
	.NUM_SRC(NUM_SRC)
) uVecArb (
	.candidate(vecCand),
	.levels(lvlVec),
	.found(vecFound),
	.winId(vecWinId),
	.winLvl(vecWinLvl)
);

level_arbiter #(
	.NUM_SRC(NUM_SRC)
) uHwArb (
	.candidate(hwCand),
	.levels({2*NUM_SRC{1'b0}}),
	.found(hwFound),
	.winId(hwWinId),
	.winLvl()
);

// a request must outrank the most urgent level already in service
always @* begin
	isrLimit = 3'd4;
	for (k = `IRQ_NUM_LEVELS - 1; k >= 0; k = k - 1) begin
		if (isr_ff[k])
			isrLimit = k[2:0];
	end
end

assign eligible = vecFound && globalMaskableAllow && ({1'b0, vecWinLvl} < isrLimit);

// service end retires the most urgent level in service
always @* begin
	isrClr = 4'h0;
	for (k = `IRQ_NUM_LEVELS - 1; k >= 0; k = k - 1) begin
		if (isr_ff[k]) begin
			isrClr = 4'h0;
			isrClr[k] = serviceEnd;
		end
	end
end

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		isr_ff <= `IRQ_ISR_RESET;
	end else begin
		if (vecAckOk)
			isr_ff <= (isr_ff & ~isrClr) | (4'h1 << vecLvl);
		else
			isr_ff <= isr_ff & ~isrClr;
	end
end

assign inServiceLevels = isr_ff;

// presented requests are registered; the ack cycle drops them so one source is not taken twice
always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		vecReq_ff <= 1'b0;
		vecId <= 5'h00;
		vecLvl <= 2'h3;
		vecBankSwitch <= 1'b0;
		hwReq_ff <= 1'b0;
		hwId <= 5'h00;
	end else begin
		vecReq_ff <= eligible && !vecAck;
		vecId <= vecWinId;
		vecLvl <= vecWinLvl;
		vecBankSwitch <= ctrlBytes[8*vecWinId + `IRQ_BIT_BANK];
		hwReq_ff <= hwFound && !hwAck;
		hwId <= hwWinId;
	end
end

assign vecReq = vecReq_ff;
assign hwReq = hwReq_ff;

// read data: control bytes on bits 7:0, mask words as word or odd-address byte
always @* begin
	nxt_rdData = 16'h0000;
	if (ctrlHit)
		nxt_rdData = {8'h00, ctrlBytes[8*ctrlIdx +: 8]};
	else if (maskLoHit)
		nxt_rdData = cpuAddr[0] ? {8'h00, maskRd[15:8]} : maskRd[15:0];
	else if (maskHiHit)
		nxt_rdData = cpuAddr[0] ? {8'h00, maskRd[31:24]} : maskRd[31:16];
end

always @(posedge sys_clk or posedge rst) begin
	if (rst)
		cpuRdData <= 16'h0000;
	else if (cpuRd)
		cpuRdData <= nxt_rdData;
end

endmodule // maskable_irq_control_flags

// File: testbench/maskable_irq_control_flags_sva.sv
// assertion checker for the maskable interrupt flags block
`timescale 1ns/1ps
module maskable_irq_control_flags_sva (
	// clock and reset
	input wire sys_clk,
	input wire rst,
	// register port
	input wire [15:0] cpuAddr,
	input wire cpuRd,
	input wire [15:0] cpuRdData,
	// cpu side
	input wire globalMaskableAllow,
	input wire serviceEnd,
	input wire [3:0] inServiceLevels,
	input wire vecReq,
	input wire [1:0] vecLvl,
	input wire vecAck,
	input wire hwReq,
	input wire hwAck
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	ack_drops_req_a: assert property (vecReq && vecAck |=> !vecReq) else $error("vecReq after ack");
	ack_sets_level_a: assert property (vecReq && vecAck |=> inServiceLevels[$past(vecLvl)])
		else $error("in-service bit not set");
	nest_blocks_a: assert property (vecReq |-> ({1'b0, inServiceLevels} & ((5'h02 << vecLvl) - 5'h01)) == 5'h00)
		else $error("request at blocked level");
	allow_gates_a: assert property (!globalMaskableAllow && !$past(globalMaskableAllow) |-> !vecReq)
		else $error("vecReq while disallowed");
	// only the most urgent in-service level may be cleared
	end_pops_a: assert property (serviceEnd && inServiceLevels != 4'h0 && !vecAck |=>
		(inServiceLevels ^ $past(inServiceLevels)) == ($past(inServiceLevels) & (~$past(inServiceLevels) + 4'h1)))
		else $error("wrong level cleared");
	hw_ack_drop_a: assert property (hwReq && hwAck |=> !hwReq) else $error("hwReq after ack");
	ctrl_spare_a: assert property (cpuRd && cpuAddr >= 16'hFFE1 && cpuAddr <= 16'hFFF9 |=> cpuRdData[3:2] == 2'h0)
		else $error("spare bits nonzero");
	mask_spare_a: assert property (cpuRd && cpuAddr == 16'hFFAE |=> cpuRdData[15:9] == 7'h7F)
		else $error("spare mask bits");
	vec_ack_c: cover property (vecReq && vecAck);
	hw_ack_c: cover property (hwReq && hwAck);
	end_c: cover property (serviceEnd && inServiceLevels != 4'h0);
endmodule // maskable_irq_control_flags_sva
bind maskable_irq_control_flags maskable_irq_control_flags_sva u_sva (.sys_clk, .rst, .cpuAddr, .cpuRd,
	.cpuRdData, .globalMaskableAllow, .serviceEnd, .inServiceLevels, .vecReq, .vecLvl, .vecAck, .hwReq, .hwAck);

// File: testbench/cpu_ack_model.sv
// cpu side model: acknowledges vectored and transfer requests after ackDly cycles
`timescale 1ns/1ps
module cpu_ack_model (
	// clock and reset
	input wire sys_clk,
	input wire rst,
	// delay and requests
	input wire [1:0] ackDly,
	input wire vecReq,
	input wire hwReq,
	// acknowledge pulses
	output wire vecAck,
	output wire hwAck
);
	reg [3:0] vecWait_ff;
	reg [3:0] hwWait_ff;
	reg vecAck_ff;
	reg hwAck_ff;
	assign vecAck = vecAck_ff;
	assign hwAck = hwAck_ff;
	// a pulse never outlives the edge that takes it, so one request is never acked twice
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			vecWait_ff <= 4'h1;
			hwWait_ff <= 4'h1;
			vecAck_ff <= 1'b0;
			hwAck_ff <= 1'b0;
		end else begin
			vecAck_ff <= vecReq && !vecAck_ff && vecWait_ff[ackDly];
			hwAck_ff <= hwReq && !hwAck_ff && hwWait_ff[ackDly];
			vecWait_ff <= (vecReq && !vecAck_ff) ? {vecWait_ff[2:0], 1'b1} : 4'h1;
			hwWait_ff <= (hwReq && !hwAck_ff) ? {hwWait_ff[2:0], 1'b1} : 4'h1;
		end
	end
endmodule // cpu_ack_model

// File: testbench/maskable_irq_control_flags_tb_top.sv
// self-checking bench for the maskable interrupt flags block
`timescale 1ns/1ps
module maskable_irq_control_flags_tb_top;
	reg sys_clk, rst, cpuWr, cpuRd, serviceEnd, hwDone, globalMaskableAllow;
	reg serialMode1, serialMode2, asyncReceiveRequest1, clockedSerial1Request;
	reg asyncReceiveRequest2, clockedSerial2Request;
	reg [15:0] cpuAddr, cpuWrData, cpuWrMask;
	reg [24:0] srcReq;
	reg [4:0] hwDoneId;
	reg [1:0] ackDly;
	reg [7:0] pick;
	wire [15:0] cpuRdData;
	wire [3:0] inServiceLevels;
	wire [4:0] vecId, hwId;
	wire [1:0] vecLvl;
	wire vecReq, vecBankSwitch, vecAck, hwReq, hwAck;
	integer failures, checks_done, i, n, best, s;
	integer lv [0:24];
	integer bs [0:24];
	int pend[$];
	logic [7:0] ackQ[$];
	logic [4:0] hwQ[$];

	maskable_irq_control_flags u_maskable_irq_control_flags (.sys_clk, .rst, .cpuAddr, .cpuWr, .cpuRd,
		.cpuWrData, .cpuWrMask, .cpuRdData, .srcReq, .asyncReceiveRequest1, .clockedSerial1Request,
		.serialMode1, .asyncReceiveRequest2, .clockedSerial2Request, .serialMode2, .globalMaskableAllow,
		.serviceEnd, .inServiceLevels, .vecReq, .vecId, .vecLvl, .vecBankSwitch, .vecAck, .hwReq, .hwId,
		.hwAck, .hwDone, .hwDoneId);
	cpu_ack_model u_cpu_ack_model (.sys_clk, .rst, .ackDly, .vecReq, .hwReq, .vecAck, .hwAck);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (vecReq && vecAck) ackQ.push_back({vecBankSwitch, vecLvl, vecId});
		if (hwReq && hwAck) hwQ.push_back(hwId);
	end

	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr(input [15:0] a, input [15:0] d, input [15:0] m);
		@(posedge sys_clk);
		cpuWr <= 1'b1;
		cpuAddr <= a;
		cpuWrData <= d;
		cpuWrMask <= m;
		@(posedge sys_clk);
		cpuWr <= 1'b0;
	endtask
	task rd(input [15:0] a, input [15:0] e, input string nm);
		@(posedge sys_clk);
		cpuRd <= 1'b1;
		cpuAddr <= a;
		@(posedge sys_clk);
		cpuRd <= 1'b0;
		#1 chk(nm, e, cpuRdData);
	endtask
	// shared positions 15 and 19 arrive on their serial lines, not on srcReq
	task pulse(input [24:0] v);
		@(posedge sys_clk);
		srcReq <= v;
		clockedSerial1Request <= v[15];
		asyncReceiveRequest2 <= v[19];
		@(posedge sys_clk);
		srcReq <= 25'h000_0000;
		clockedSerial1Request <= 1'b0;
		asyncReceiveRequest2 <= 1'b0;
	endtask
	task waitq(input bit hw);
		integer w;
		w = 0;
		while ((hw ? hwQ.size() : ackQ.size()) == 0 && w < 50) begin
			@(posedge sys_clk);
			#1 w++;
		end
		if (w == 50) begin
			failures++;
			$display("MISMATCH ack wait expected ack seen none");
			report_and_stop;
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		{cpuWr, cpuRd, serviceEnd, hwDone, serialMode2, asyncReceiveRequest1} = 6'h00;
		{clockedSerial1Request, asyncReceiveRequest2, clockedSerial2Request} = 3'h0;
		{rst, serialMode1, globalMaskableAllow} = 3'h7;
		{cpuAddr, cpuWrData, cpuWrMask, srcReq, hwDoneId, ackDly} = 0;
		failures = 0;
		checks_done = 0;
		void'($urandom(32'h28f7));
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		for (i = 0; i < 4; i++) rd(16'(16'hFFF6 + i), 16'h0043, "ctrl reset");
		rd(16'hFFAC, 16'hFFFF, "mask lo reset");
		rd(16'hFFAE, 16'hFFFF, "mask hi reset");
		wr(16'hFFF6, 16'h00FF, 16'h00FF);
		rd(16'hFFF6, 16'h00F3, "ctrl spare");
		wr(16'hFFF6, 16'h0000, 16'h00FF);
		rd(16'hFFAE, 16'hFFDF, "mask alias");
		wr(16'hFFAF, 16'h0000, 16'h00FF);
		rd(16'hFFAE, 16'hFEDF, "mask byte");
		rd(16'hFFF9, 16'h0003, "ctrl alias");
		wr(16'hFFAC, 16'h0000, 16'h0004);
		rd(16'hFFE3, 16'h0003, "mask bit");
		$display("test registers done");
		for (n = 0; n < 4; n++) begin
			ackDly <= 2'($urandom);
			for (i = 12; i < 20; i++) begin
				lv[i] = $urandom % 4;
				bs[i] = $urandom % 2;
				wr(16'(16'hFFE1 + i), 16'(bs[i] * 16 + lv[i]), 16'h00FF);
			end
			pick = 8'($urandom) | 8'h01;
			pulse({5'h00, pick, 12'h000});
			for (i = 0; i < 8; i++) if (pick[i]) pend.push_back(12 + i);
			while (pend.size() > 0) begin
				best = 0;
				for (i = 1; i < pend.size(); i++) if (lv[pend[i]] < lv[pend[best]]) best = i;
				waitq(1'b0);
				s = pend[best];
				chk("ack", 16'({bs[s][0], 2'(lv[s]), 5'(s)}), 16'(ackQ.pop_front()));
				chk("in service", 16'(4'h1 << lv[s]), 16'(inServiceLevels));
				pend.delete(best);
				@(posedge sys_clk);
				serviceEnd <= 1'b1;
				@(posedge sys_clk);
				serviceEnd <= 1'b0;
			end
			$display("test arbitration round %0d done", n);
		end
		wr(16'hFFAC, 16'h2000, 16'h2000);
		pulse(25'h000_2000);
		repeat (6) @(posedge sys_clk);
		#1 chk("masked ack", 16'h0000, 16'(ackQ.size()));
		rd(16'hFFEE, 16'(192 + bs[13] * 16 + lv[13]), "masked pending");
		rd(16'hFFAC, 16'h2FFB, "mask kept");
		globalMaskableAllow <= 1'b0;
		wr(16'hFFEE, 16'(224 + lv[13]), 16'h00FF);
		repeat (6) @(posedge sys_clk);
		#1 chk("masked transfer", 16'h0000, 16'(hwQ.size()));
		wr(16'hFFAC, 16'h0000, 16'h2000);
		waitq(1'b1);
		chk("transfer id", 16'h000D, 16'(hwQ.pop_front()));
		@(posedge sys_clk);
		hwDone <= 1'b1;
		hwDoneId <= 5'h0D;
		@(posedge sys_clk);
		hwDone <= 1'b0;
		rd(16'hFFEE, 16'(lv[13]), "transfer done");
		chk("no vectored", 16'h0000, 16'(ackQ.size()));
		$display("test mask and transfer done");
		report_and_stop;
	end
endmodule // maskable_irq_control_flags_tb_top
